// ===== hdl/aspc_serial_port.v
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "aspc_map.vh"

// Overview of operation
// - Port clock keeps running in sleep only when sleep-run enable is set.
// - Running-status flag reads one while the port is active and clocked.
// - Two-bit select picks reference, fast RC, system or peripheral bus tick.
// - On overrun, receiver keeps running if overflow-run set, else stops accepting.
// - Module disabled releases all pins and idles; enabled drives TX when transmitter enabled, RTS per pin usage select.
// - RTS select: set gives simplex RTS, clear gives flow-control RTS.
// - Auto-baud measures next 0x55 character, then hardware clears the bit.
// - Receive polarity bit set means receive input idles low.
// - High-speed bit picks 4x oversampling, otherwise 16x.
// - Format field: nine bits, eight odd, eight even, eight no parity.
// - Stop select appends two stop bits when set, one when clear.
// - Address match compares only bit positions whose mask bit is one.
// - Address detect acts only in nine-bit format.
// - Transmit flag: buffer empty, all sent, or slot free.
// - Transmit polarity sets idle level; meaning swaps with infrared enabled.
// - Receiver disabled ignores the receive input entirely.
// - Break sends start, twelve zeros, stop, then hardware clears it.
// - Clearing transmitter enable aborts sending and empties the buffer.
// - Shift-empty reads one only when shifter and buffer are both empty.
// - Receive flag: three-quarters full, half full, or not empty.
// - Overrun sets on overflow; software clear empties receive buffer and shifter.
// - Parity and framing error flags describe the current character.
module aspc_serial_port (
    input wire clk,
    input wire nrst,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire reference_clock_out,
    input wire fast_rc_oscillator,
    input wire system_clock,
    input wire peripheral_bus_clock,
    input wire sleep_mode,
    input wire idle_mode,
    input wire rx_pin,
    input wire cts_n_pin,
    output reg tx_pin,
    output reg tx_oe,
    output reg rts_n_pin,
    output reg rts_oe,
    output reg tx_irq,
    output reg rx_irq
);

// ----------------------------------------
// State codes
// ----------------------------------------
localparam RX_IDLE = 4'b0001;
localparam RX_START = 4'b0010;
localparam RX_DATA = 4'b0100;
localparam RX_STOP = 4'b1000;
localparam TX_IDLE = 2'b01;
localparam TX_SHIFT = 2'b10;

reg [31:0] mode_q;
reg [31:0] stat_q;
reg overrun;
reg [15:0] div_q;
reg [15:0] div_cnt;
reg rx_s1, rx_s2, cts_s1, cts_s2;
reg rx_prev;
reg aw_held, w_held;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
reg [3:0] rx_st;
reg [3:0] rx_os;
reg [3:0] rx_bits;
reg [8:0] rx_sh;
reg rx_push, ovr_set, ab_done, addr_hit;
reg [10:0] rx_pdata;
reg [23:0] ab_cnt;
reg [2:0] ab_edges;
reg [1:0] tx_st;
reg [3:0] tx_os;
reg [3:0] tx_left;
reg [14:0] tx_frame;
reg tx_brk_fr, brk_done;
reg [8:0] tx_mem [0:7];
reg [2:0] tx_wp, tx_rp;
reg [3:0] tx_cnt;
reg [10:0] rx_mem [0:7];
reg [2:0] rx_wp, rx_rp;
reg [3:0] rx_cnt;
reg [14:0] tx_load;
reg [3:0] tx_len;

// ----------------------------------------
// Field decode
// ----------------------------------------
wire on = mode_q[`ASPC_M_ENABLE];
wire [1:0] ck_sel = mode_q[`ASPC_M_CKSEL+1:`ASPC_M_CKSEL];
wire [1:0] fmt = mode_q[`ASPC_M_FORMAT+1:`ASPC_M_FORMAT];
wire [1:0] pin_usage_select = mode_q[`ASPC_M_PINUSE+1:`ASPC_M_PINUSE];
wire hi_speed = mode_q[`ASPC_M_HISPEED];
wire autobaud_enable = mode_q[`ASPC_M_AUTOBAUD];
wire overflow_keep_running = mode_q[`ASPC_M_OVFRUN];
wire receiver_enable = stat_q[`ASPC_S_RXEN];
wire transmitter_enable = stat_q[`ASPC_S_TXEN];
wire send_break = stat_q[`ASPC_S_BREAK];
wire [7:0] match_mask = stat_q[`ASPC_S_MASK+7:`ASPC_S_MASK];
wire [7:0] match_addr = stat_q[`ASPC_S_ADDR+7:`ASPC_S_ADDR];
wire [1:0] tx_isel = stat_q[`ASPC_S_TXIRQ+1:`ASPC_S_TXIRQ];
wire [1:0] rx_isel = stat_q[`ASPC_S_RXIRQ+1:`ASPC_S_RXIRQ];

// Port clock gating by sleep and idle
wire clk_run = !(sleep_mode && !mode_q[`ASPC_M_SLPRUN]) &&
               !(idle_mode && mode_q[`ASPC_M_IDLESTOP]);
wire port_active = on && clk_run;
wire sel_tick = (ck_sel == 2'b11) ? reference_clock_out :
                (ck_sel == 2'b10) ? fast_rc_oscillator :
                (ck_sel == 2'b01) ? system_clock : peripheral_bus_clock;
wire port_tick = port_active && sel_tick;
wire os_tick = port_tick && (div_cnt >= div_q);
wire [3:0] os_last = hi_speed ? 4'h3 : 4'hF;
wire [3:0] os_mid = hi_speed ? 4'h1 : 4'h7;

// Receive line selection
wire tx_raw = tx_frame[0];
wire rx_enabled = on && receiver_enable;
wire rx_line = mode_q[`ASPC_M_LOOP] ? tx_raw : (rx_s2 ^ mode_q[`ASPC_M_RX_POLARITY_INVERT]);
wire rx_in = rx_enabled ? rx_line : 1'b1;
wire rx_fall = rx_prev && !rx_in;
wire rx_stall = overrun && !overflow_keep_running;

// Received character decode
wire [3:0] rx_nbits = (fmt == 2'b00) ? 4'h8 : 4'h9;
wire [8:0] rx_d9 = (fmt == 2'b00) ? {1'b0, rx_sh[8:1]} :
                   (fmt == 2'b11) ? rx_sh : {1'b0, rx_sh[7:0]};
wire rx_parity_error_flag = (fmt == 2'b01) ? ^rx_sh : (fmt == 2'b10) ? ~^rx_sh : 1'b0;
wire addr_mode = stat_q[`ASPC_S_ADDREN] && (fmt == 2'b11);
wire addr_match = ((rx_d9[7:0] ^ match_addr) & match_mask) == 8'h00;
wire rx_keep = !addr_mode || (rx_d9[8] ? addr_match : addr_hit);

// Bus handshakes and side effects
wire wr_go = aw_held && w_held && !s_axi_bvalid;
wire ar_go = s_axi_arvalid && s_axi_arready;
wire [31:0] bmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
wire wr_mode = wr_go && (aw_addr == `ASPC_MODE_OFS);
wire wr_stat = wr_go && (aw_addr == `ASPC_STAT_OFS);
wire overrun_error_flag_clr = wr_stat && w_strb[0] && !w_data[`ASPC_S_OVERRUN] && overrun;
wire tx_flush = !transmitter_enable;
wire tx_push = wr_go && (aw_addr == `ASPC_TXD_OFS) && w_strb[0] &&
               (tx_cnt != `ASPC_DEPTH) && !tx_flush;
wire rx_pop = ar_go && (s_axi_araddr == `ASPC_RXD_OFS) && (rx_cnt != 4'h0);

// Transmit start and status
wire cts_ok = (pin_usage_select != 2'b10) || !cts_s2;
wire tx_start = tx_st[0] && os_tick && on && transmitter_enable && cts_ok;
wire tx_pop = tx_start && !send_break && (tx_cnt != 4'h0);
wire tx_full = (tx_cnt == `ASPC_DEPTH);
wire tx_shift_empty = tx_st[0] && (tx_cnt == 4'h0);
wire [10:0] rx_head = rx_mem[rx_rp];
wire rx_data_available = (rx_cnt != 4'h0);
wire [31:0] stat_rd = {stat_q[31:10], tx_full, tx_shift_empty, stat_q[7:5],
                       rx_st[0], rx_data_available & rx_head[10],
                       rx_data_available & rx_head[9], overrun, rx_data_available};

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
always @(posedge clk) begin
    if (!nrst) begin
        rx_s1 <= 1'b1;
        rx_s2 <= 1'b1;
        cts_s1 <= 1'b1;
        cts_s2 <= 1'b1;
        rx_prev <= 1'b1;
    end else begin
        rx_s1 <= rx_pin;
        rx_s2 <= rx_s1;
        cts_s1 <= cts_n_pin;
        cts_s2 <= cts_s1;
        rx_prev <= rx_in;
    end
end

// ----------------------------------------
// Bus slave and control registers
// ----------------------------------------
always @(posedge clk) begin
    if (!nrst) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'b00;
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= 2'b00;
        s_axi_rdata <= 32'h0000_0000;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 8'h00;
        w_data <= 32'h0000_0000;
        w_strb <= 4'h0;
        mode_q <= `ASPC_MODE_RST;
        stat_q <= `ASPC_STAT_RST;
        overrun <= 1'b0;
    end else begin
        // Address and data captured in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (!aw_held && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (!w_held && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
        if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == `ASPC_MODE_OFS || aw_addr == `ASPC_STAT_OFS ||
                            aw_addr == `ASPC_TXD_OFS || aw_addr == `ASPC_RXD_OFS) ?
                           2'b00 : 2'b10;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        // Read channel, one outstanding read
        if (ar_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `ASPC_MODE_OFS: s_axi_rdata <= {mode_q[31:23], port_active, mode_q[21:0]};
                `ASPC_STAT_OFS: s_axi_rdata <= stat_rd;
                `ASPC_RXD_OFS: s_axi_rdata <= {23'h00_0000, rx_head[8:0]};
                `ASPC_TXD_OFS: s_axi_rdata <= 32'h0000_0000;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
        // Register writes, then hardware clears
        if (wr_mode)
            mode_q <= (mode_q & ~(bmask & `ASPC_MODE_WMASK)) |
                      (w_data & bmask & `ASPC_MODE_WMASK);
        if (ab_done)
            mode_q[`ASPC_M_AUTOBAUD] <= 1'b0;
        if (wr_stat)
            stat_q <= (stat_q & ~(bmask & `ASPC_STAT_WMASK)) |
                      (w_data & bmask & `ASPC_STAT_WMASK);
        if (brk_done)
            stat_q[`ASPC_S_BREAK] <= 1'b0;
        // Overrun: hardware set wins over software clear
        if (ovr_set)
            overrun <= 1'b1;
        else if (overrun_error_flag_clr)
            overrun <= 1'b0;
    end
end

// ----------------------------------------
// Oversample divider and auto-baud
// ----------------------------------------
always @(posedge clk) begin
    if (!nrst) begin
        div_cnt <= 16'h0000;
        div_q <= `ASPC_DIV_RST;
        ab_cnt <= 24'h00_0000;
        ab_edges <= 3'h0;
        ab_done <= 1'b0;
    end else begin
        ab_done <= 1'b0;
        if (port_tick)
            div_cnt <= os_tick ? 16'h0000 : div_cnt + 16'h0001;
        if (!autobaud_enable || !rx_enabled) begin
            ab_edges <= 3'h0;
        end else begin
            if (port_tick && ab_edges != 3'h0)
                ab_cnt <= ab_cnt + 24'h00_0001;
            // Sync character gives five falling edges over eight bits
            if (rx_fall && rx_st[0] && !ab_done) begin
                if (ab_edges == 3'h0) begin
                    ab_cnt <= 24'h00_0000;
                    ab_edges <= 3'h1;
                end else if (ab_edges == 3'h4) begin
                    div_q <= hi_speed ? ab_cnt[20:5] : ab_cnt[22:7];
                    ab_edges <= 3'h0;
                    ab_done <= 1'b1;
                end else begin
                    ab_edges <= ab_edges + 3'h1;
                end
            end
        end
    end
end

// ----------------------------------------
// Receiver
// ----------------------------------------
always @(posedge clk) begin
    if (!nrst) begin
        rx_st <= RX_IDLE;
        rx_os <= 4'h0;
        rx_bits <= 4'h0;
        rx_sh <= 9'h000;
        rx_push <= 1'b0;
        rx_pdata <= 11'h000;
        ovr_set <= 1'b0;
        addr_hit <= 1'b0;
    end else begin
        rx_push <= 1'b0;
        ovr_set <= 1'b0;
        if (!rx_enabled || overrun_error_flag_clr) begin
            rx_st <= RX_IDLE;
            rx_sh <= 9'h000;
        end else begin
            case (rx_st)
                RX_IDLE: begin
                    if (rx_fall && !autobaud_enable && !rx_stall) begin
                        rx_st <= RX_START;
                        rx_os <= 4'h0;
                    end
                end
                RX_START: begin
                    if (os_tick) begin
                        if (rx_os == os_mid) begin
                            rx_st <= rx_in ? RX_IDLE : RX_DATA;
                            rx_os <= 4'h0;
                            rx_bits <= 4'h0;
                        end else begin
                            rx_os <= rx_os + 4'h1;
                        end
                    end
                end
                RX_DATA: begin
                    if (os_tick) begin
                        if (rx_os == os_last) begin
                            rx_os <= 4'h0;
                            rx_sh <= {rx_in, rx_sh[8:1]};
                            rx_bits <= rx_bits + 4'h1;
                            if (rx_bits == rx_nbits - 4'h1)
                                rx_st <= RX_STOP;
                        end else begin
                            rx_os <= rx_os + 4'h1;
                        end
                    end
                end
                RX_STOP: begin
                    if (os_tick) begin
                        if (rx_os == os_last) begin
                            rx_st <= RX_IDLE;
                            if (addr_mode && rx_d9[8])
                                addr_hit <= addr_match;
                            if (rx_cnt == `ASPC_DEPTH) begin
                                ovr_set <= 1'b1;
                            end else if (rx_keep) begin
                                rx_push <= 1'b1;
                                rx_pdata <= {rx_parity_error_flag, !rx_in, rx_d9};
                            end
                        end else begin
                            rx_os <= rx_os + 4'h1;
                        end
                    end
                end
                default: rx_st <= RX_IDLE;
            endcase
        end
    end
end

// ----------------------------------------
// Transmit frame builder
// ----------------------------------------
always @* begin
    tx_load = 15'h7FFF;
    tx_len = 4'hA + {3'b000, (fmt != 2'b00)} + {3'b000, mode_q[`ASPC_M_STOP2]};
    if (send_break) begin
        tx_load[12:0] = 13'h0000;
        tx_len = 4'hE;
    end else begin
        tx_load[8:0] = {tx_mem[tx_rp][7:0], 1'b0};
        if (fmt == 2'b11)
            tx_load[9] = tx_mem[tx_rp][8];
        else if (fmt == 2'b01)
            tx_load[9] = ^tx_mem[tx_rp][7:0];
        else if (fmt == 2'b10)
            tx_load[9] = ~^tx_mem[tx_rp][7:0];
    end
end

// ----------------------------------------
// Transmitter
// ----------------------------------------
always @(posedge clk) begin
    if (!nrst) begin
        tx_st <= TX_IDLE;
        tx_os <= 4'h0;
        tx_left <= 4'h0;
        tx_frame <= 15'h7FFF;
        tx_brk_fr <= 1'b0;
        brk_done <= 1'b0;
    end else begin
        brk_done <= 1'b0;
        if (tx_flush || !on) begin
            tx_st <= TX_IDLE;
            tx_frame <= 15'h7FFF;
        end else begin
            case (tx_st)
                TX_IDLE: begin
                    if (tx_start && (send_break || tx_cnt != 4'h0)) begin
                        tx_st <= TX_SHIFT;
                        tx_os <= 4'h0;
                        tx_frame <= tx_load;
                        tx_left <= tx_len;
                        tx_brk_fr <= send_break;
                    end
                end
                TX_SHIFT: begin
                    if (os_tick) begin
                        if (tx_os == os_last) begin
                            tx_os <= 4'h0;
                            tx_frame <= {1'b1, tx_frame[14:1]};
                            tx_left <= tx_left - 4'h1;
                            if (tx_left == 4'h1) begin
                                tx_st <= TX_IDLE;
                                brk_done <= tx_brk_fr;
                            end
                        end else begin
                            tx_os <= tx_os + 4'h1;
                        end
                    end
                end
                default: tx_st <= TX_IDLE;
            endcase
        end
    end
end

// ----------------------------------------
// Transmit and receive buffers
// ----------------------------------------
always @(posedge clk) begin
    if (!nrst || tx_flush) begin
        tx_wp <= 3'h0;
        tx_rp <= 3'h0;
        tx_cnt <= 4'h0;
    end else begin
        if (tx_push) begin
            tx_mem[tx_wp] <= w_data[8:0];
            tx_wp <= tx_wp + 3'h1;
        end
        if (tx_pop)
            tx_rp <= tx_rp + 3'h1;
        if (tx_push && !tx_pop)
            tx_cnt <= tx_cnt + 4'h1;
        else if (tx_pop && !tx_push)
            tx_cnt <= tx_cnt - 4'h1;
    end
end

always @(posedge clk) begin
    if (!nrst || overrun_error_flag_clr) begin
        rx_wp <= 3'h0;
        rx_rp <= 3'h0;
        rx_cnt <= 4'h0;
    end else begin
        if (rx_push) begin
            rx_mem[rx_wp] <= rx_pdata;
            rx_wp <= rx_wp + 3'h1;
        end
        if (rx_pop)
            rx_rp <= rx_rp + 3'h1;
        if (rx_push && !rx_pop)
            rx_cnt <= rx_cnt + 4'h1;
        else if (rx_pop && !rx_push)
            rx_cnt <= rx_cnt - 4'h1;
    end
end

// ----------------------------------------
// Registered pins and flags
// ----------------------------------------
always @(posedge clk) begin
    if (!nrst) begin
        tx_pin <= 1'b1;
        tx_oe <= 1'b0;
        rts_n_pin <= 1'b1;
        rts_oe <= 1'b0;
        tx_irq <= 1'b0;
        rx_irq <= 1'b0;
    end else begin
        tx_oe <= on && transmitter_enable;
        tx_pin <= tx_raw ^ (mode_q[`ASPC_M_INFRA] ?
                  !stat_q[`ASPC_S_TXINV] : stat_q[`ASPC_S_TXINV]);
        rts_oe <= on && (pin_usage_select == 2'b01 || pin_usage_select == 2'b10);
        rts_n_pin <= mode_q[`ASPC_M_RTSMODE] ? tx_shift_empty :
                     (rx_cnt == `ASPC_DEPTH);
        case (tx_isel)
            2'b10: tx_irq <= transmitter_enable && (tx_cnt == 4'h0);
            2'b01: tx_irq <= transmitter_enable && tx_shift_empty;
            2'b00: tx_irq <= transmitter_enable && !tx_full;
            default: tx_irq <= 1'b0;
        endcase
        case (rx_isel)
            2'b10: rx_irq <= (rx_cnt >= `ASPC_3QTR);
            2'b01: rx_irq <= (rx_cnt >= `ASPC_HALF);
            2'b00: rx_irq <= rx_data_available;
            default: rx_irq <= 1'b0;
        endcase
    end
end

endmodule

// ===== hdl/aspc_map.vh
`ifndef ASPC_MAP_VH
`define ASPC_MAP_VH
// Register byte offsets
`define ASPC_MODE_OFS 8'h00
`define ASPC_STAT_OFS 8'h10
`define ASPC_TXD_OFS 8'h20
`define ASPC_RXD_OFS 8'h30
// Reset values and software-writable masks
`define ASPC_MODE_RST 32'h0000_0000
`define ASPC_STAT_RST 32'h0000_0000
`define ASPC_MODE_WMASK 32'h0087_BBFF
`define ASPC_STAT_WMASK 32'hFFFF_FCE0
`define ASPC_DIV_RST 16'h000D
`define ASPC_DEPTH 4'h8
`define ASPC_HALF 4'h4
`define ASPC_3QTR 4'h6
// Mode register field positions
`define ASPC_M_SLPRUN 23
`define ASPC_M_ACTIVE 22
`define ASPC_M_CKSEL 17
`define ASPC_M_OVFRUN 16
`define ASPC_M_ENABLE 15
`define ASPC_M_IDLESTOP 13
`define ASPC_M_INFRA 12
`define ASPC_M_RTSMODE 11
`define ASPC_M_PINUSE 8
`define ASPC_M_LOOP 6
`define ASPC_M_AUTOBAUD 5
`define ASPC_M_RX_POLARITY_INVERT 4
`define ASPC_M_HISPEED 3
`define ASPC_M_FORMAT 1
`define ASPC_M_STOP2 0
// Status register field positions
`define ASPC_S_MASK 24
`define ASPC_S_ADDR 16
`define ASPC_S_TXIRQ 14
`define ASPC_S_TXINV 13
`define ASPC_S_RXEN 12
`define ASPC_S_BREAK 11
`define ASPC_S_TXEN 10
`define ASPC_S_RXIRQ 6
`define ASPC_S_ADDREN 5
`define ASPC_S_OVERRUN 1
`endif

// ===== tb/aspc_serial_port_props.sv
`timescale 1ns/1ps
module aspc_serial_port_props (
    input wire clk,
    input wire nrst,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire tx_pin,
    input wire tx_oe,
    input wire rts_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Write taken on both channels, then decoded targets
    sequence s_wtake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_off;
        s_wtake ##0 (s_axi_awaddr == 8'h00 && !s_axi_wdata[15]);
    endsequence
    sequence s_txoff;
        s_wtake ##0 (s_axi_awaddr == 8'h10 && s_axi_wdata[13:10] == 4'h0);
    endsequence
    property p_wr_lat; s_wtake |-> ##2 s_axi_bvalid; endproperty
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside {8'h00, 8'h10, 8'h20, 8'h30})
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000;
    endproperty
    property p_refuse; s_wtake |=> !s_axi_awready && !s_axi_wready; endproperty
    property p_off; s_off |-> ##[1:4] (!tx_oe && !rts_oe); endproperty
    property p_abort; s_txoff |-> ##[1:4] tx_pin [*3]; endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write response late");
    a_rd_lat: assert property (p_rd_lat) else $error("read response late");
    a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    a_refuse: assert property (p_refuse) else $error("ready held during write");
    a_off: assert property (p_off) else $error("pins still driven when off");
    a_abort: assert property (p_abort) else $error("transmit not aborted");
endmodule

// ===== tb/aspc_remote_serial.sv
`timescale 1ns/1ps
module aspc_remote_serial #(parameter int BIT = 56) (
    input wire clk,
    input wire tx,
    output logic rx,
    output logic [9:0] got
);
    initial rx = 1'b1; // Idle high line
    // Capture nine bits and the bit after them, mid-bit, LSB first
    always begin
        @(negedge tx);
        repeat (BIT / 2) @(posedge clk);
        for (int k = 0; k < 10; k++) begin
            repeat (BIT) @(posedge clk);
            got[k] = tx;
        end
    end
    // Send start, eight data bits LSB first, one stop
    task put(input [7:0] b);
        begin
            for (int k = 0; k < 10; k++) begin
                @(posedge clk);
                rx <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : b[k-1];
                repeat (BIT - 1) @(posedge clk);
            end
        end
    endtask
endmodule

// ===== tb/aspc_serial_port_tb_top.sv
`timescale 1ns/1ps
module aspc_serial_port_tb_top;
    logic clk = 1'b0, nrst = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, d;
    logic [3:0] s_axi_wstrb = 4'hF, src = 4'h1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, sleep_mode = 0, idle_mode = 0, cts_n_pin = 0;
    logic [1:0] r;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire reference_clock_out, fast_rc_oscillator, system_clock, peripheral_bus_clock;
    wire rx_pin, tx_pin, tx_oe, rts_n_pin, rts_oe, tx_irq, rx_irq;
    int fails = 0, comparisons = 0;
    logic [1:0] fmt_t [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
    logic [9:0] exp_t [4] = '{10'h2A5, 10'h3A5, 10'h2A5, 10'h3A5};
    assign {reference_clock_out, fast_rc_oscillator, system_clock, peripheral_bus_clock} = src;
    aspc_serial_port uut (.*);
    aspc_remote_serial #(.BIT(56)) p (.clk(clk), .tx(tx_pin), .rx(rx_pin), .got());
    always #20 clk = ~clk;
    task wr(input [7:0] a, input [31:0] v);
        begin
            s_axi_awaddr <= a; s_axi_wdata <= v;
            s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
            do begin
                @(posedge clk);
                if (s_axi_awready) s_axi_awvalid <= 0;
                if (s_axi_wready) s_axi_wvalid <= 0;
            end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
            while (!s_axi_bvalid) @(posedge clk);
            s_axi_bready <= 0;
            @(posedge clk);
        end
    endtask
    task rd(input [7:0] a);
        begin
            s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
            do @(posedge clk); while (!s_axi_arready);
            s_axi_arvalid <= 0;
            do @(posedge clk); while (!s_axi_rvalid);
            d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
            @(posedge clk);
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons++;
            if (got !== exp) begin
                fails++;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task finish_test;
        if (fails == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test;
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1;
        repeat (2) @(posedge clk);
        rd(8'h00); chk(d, 32'h0000_0000);
        rd(8'h10); chk(d & 32'h0000_0100, 32'h0000_0100);
        rd(8'h44); chk({30'h0, r}, 32'h0000_0002);
        wr(8'h10, 32'h0000_1000);
        wr(8'h10, 32'h0000_1400);
        for (int i = 0; i < 4; i++) begin
            src <= 4'h1 << i;
            wr(8'h00, 32'h0000_0000);
            wr(8'h00, 32'h0000_8008 | (32'(i) << 17) | (32'(fmt_t[i]) << 1));
            wr(8'h20, 32'h0000_00A5);
            rd(8'h10); chk(d & 32'h0000_0100, 32'h0000_0000);
            repeat (700) @(posedge clk);
            chk({22'h0, p.got}, {22'h0, exp_t[i]});
            rd(8'h10); chk(d & 32'h0000_0100, 32'h0000_0100);
        end
        rd(8'h00); chk(d & 32'h0040_0000, 32'h0040_0000);
        sleep_mode <= 1;
        rd(8'h00); chk(d & 32'h0040_0000, 32'h0000_0000);
        sleep_mode <= 0;
        chk(tx_irq, 1);
        wr(8'h10, 32'h0000_1C00);
        repeat (900) @(posedge clk);
        chk({22'h0, p.got}, 32'h0000_0000);
        rd(8'h10); chk(d & 32'h0000_0900, 32'h0000_0100);
        wr(8'h20, 32'h0000_00A5);
        repeat (100) @(posedge clk);
        wr(8'h10, 32'h0000_0000);
        rd(8'h10); chk(d & 32'h0000_0300, 32'h0000_0100);
        chk(tx_irq, 0);
        wr(8'h10, 32'h0000_0400);
        p.put(8'h33);
        repeat (60) @(posedge clk);
        rd(8'h10); chk(d & 32'h0000_0001, 32'h0000_0000);
        wr(8'h10, 32'h0000_1400);
        p.put(8'h5A);
        repeat (60) @(posedge clk);
        chk(rx_irq, 1);
        chk(rts_n_pin, 0);
        rd(8'h10); chk(d & 32'h0000_001D, 32'h0000_0011);
        rd(8'h30); chk(d & 32'h0000_01FF, 32'h0000_005A);
        chk(rx_irq, 0);
        finish_test;
    end
endmodule
bind aspc_serial_port aspc_serial_port_props chk_i (.*);
